// *** core/dmr_pkg.sv ***
// Shared constants and types of the DMA channel register set
package dmr_pkg;
   localparam int NUM_CHAN = 8;
   localparam int ADDR_W = 12;
   // Per-channel register indices, byte address = base + index * 4
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_REQ = 3'h1;
   localparam logic [2:0] IDX_STA = 3'h2;
   localparam logic [2:0] IDX_STB = 3'h3;
   localparam logic [2:0] IDX_PAD = 3'h4;
   localparam logic [2:0] IDX_CNT = 3'h5;
   // Channel x sits at CHAN_STRIDE * x, shared block above it
   localparam logic [ADDR_W-1:0] CHAN_STRIDE = 12'h020;
   localparam logic [ADDR_W-1:0] SHARED_BASE = 12'h100;
   // Shared register indices within the shared block
   localparam logic [2:0] IDX_COLL = 3'h0;
   localparam logic [2:0] IDX_PPSTAT = 3'h1;
   localparam logic [2:0] IDX_IRQ_FLAG = 3'h2;
   localparam logic [2:0] IDX_IRQ_CLR = 3'h3;
   localparam logic [2:0] IDX_IRQ_EN = 3'h4;
   localparam logic [2:0] IDX_IRQ_PRIO = 3'h5;
   // Control register field positions
   localparam int CTL_ON = 15;
   localparam int CTL_SIZE = 14;
   localparam int CTL_DIR = 13;
   localparam int CTL_HALF = 12;
   localparam int CTL_DUMMY_PERIPHERAL_WRITE = 11;
   localparam int CTL_AM_LO = 4;
   localparam int CTL_OP_LO = 0;
   localparam logic [15:0] CTL_WMASK = 16'hF833;
   // Reset values
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [23:0] PRIO_RST = 24'h000000;
   // Field encodings
   localparam logic [1:0] AM_POSTINC = 2'h0;
   localparam logic [1:0] AM_NOINC = 2'h1;
   localparam logic [1:0] AM_PERIPH = 2'h2;
   localparam logic [1:0] OPM_CONT = 2'h0;
   localparam logic [1:0] OPM_ONESHOT = 2'h1;
   localparam logic [1:0] OPM_CONT_PP = 2'h2;
   localparam logic [1:0] OPM_ONESHOT_PP = 2'h3;

   // Decoded channel configuration handed to the transfer engine
   typedef struct packed {
      logic channel_on;
      logic byte_unit;
      logic ram_to_periph;
      logic irq_at_half;
      logic dummy_peripheral_write;
      logic periph_indirect;
      logic post_inc;
      logic ping_pong;
      logic one_shot;
      logic [1:0] addressing_kind;
      logic [15:0] request_select;
      logic [15:0] ram_start_a;
      logic [15:0] ram_start_b;
      logic [15:0] periph_address;
      logic [9:0] transfer_count;
   } dmr_chan_cfg_t;

   // Control word as software reads it back
   function automatic logic [15:0] dmr_ctrl_word(dmr_chan_cfg_t c);
      logic [15:0] w;
      w = 16'h0000;
      w[CTL_ON] = c.channel_on;
      w[CTL_SIZE] = c.byte_unit;
      w[CTL_DIR] = c.ram_to_periph;
      w[CTL_HALF] = c.irq_at_half;
      w[CTL_DUMMY_PERIPHERAL_WRITE] = c.dummy_peripheral_write;
      w[CTL_AM_LO+:2] = c.addressing_kind;
      w[CTL_OP_LO+:2] = {c.ping_pong, c.one_shot};
      return w;
   endfunction
endpackage

// *** core/dmr_chan.sv ***
// One channel's register copy with decoded configuration
module dmr_chan
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Write strobe from the bus slave
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [15:0] wr_data,
   // Configuration out
   output dmr_pkg::dmr_chan_cfg_t cfg
);
   // Plain storage; the raw null-write bit is kept so it reads back
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg <= '0;
      end else if (wr_en) begin
         unique case (wr_idx)
            IDX_CTRL: begin // see R06
               cfg.channel_on <= wr_data[CTL_ON]; // see R10
               cfg.byte_unit <= wr_data[CTL_SIZE]; // see R15
               cfg.ram_to_periph <= wr_data[CTL_DIR]; // see R11
               cfg.irq_at_half <= wr_data[CTL_HALF]; // see R12
               cfg.dummy_peripheral_write <= wr_data[CTL_DUMMY_PERIPHERAL_WRITE]; // see R16
               cfg.addressing_kind <= wr_data[CTL_AM_LO+:2]; // see R13
               cfg.periph_indirect <= wr_data[CTL_AM_LO+:2] == AM_PERIPH;
               cfg.post_inc <= wr_data[CTL_AM_LO+:2] == AM_POSTINC;
               cfg.ping_pong <= wr_data[CTL_OP_LO+1]; // see R14
               cfg.one_shot <= wr_data[CTL_OP_LO]; // see R14
            end
            IDX_REQ: cfg.request_select <= wr_data; // see R02
            IDX_STA: cfg.ram_start_a <= wr_data; // see R08
            IDX_STB: cfg.ram_start_b <= wr_data; // see R08
            IDX_PAD: cfg.periph_address <= wr_data;
            IDX_CNT: cfg.transfer_count <= wr_data[9:0]; // see R03
            default: ;
         endcase
      end
   end

   property p_ctrl_write;
      @(posedge core_clk) disable iff (!rst_b)
      wr_en && wr_idx == IDX_CTRL |=>
         dmr_ctrl_word(cfg) == ($past(wr_data) & CTL_WMASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) // see R10
      else $error("control write not stored");

   property p_start_write;
      @(posedge core_clk) disable iff (!rst_b)
      wr_en && wr_idx == IDX_STB |=> cfg.ram_start_b == $past(wr_data);
   endproperty
   a_start_write: assert property (p_start_write) // see R08
      else $error("start address write not stored");

   property p_count_width;
      @(posedge core_clk) disable iff (!rst_b)
      wr_en && wr_idx == IDX_CNT |=>
         cfg.transfer_count == $past(wr_data[9:0]) ##1
         cfg.transfer_count == $past(cfg.transfer_count) || $past(wr_en);
   endproperty
   a_count_width: assert property (p_count_width) // see R03
      else $error("transfer count not held");
endmodule

// *** core/dmr_irq.sv ***
// Sticky channel interrupt flags, enables and the level output
module dmr_irq
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Events and software access
   input wire logic [7:0] evt,
   input wire logic clr_we,
   input wire logic en_we,
   input wire logic [7:0] wr_data,
   // State out
   output logic [7:0] flag_q,
   output logic [7:0] en_q,
   output logic irq_q
);
   // Set beats clear so an event landing on a clear is kept
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flag_q <= 8'h00;
      end else begin
         flag_q <= (flag_q & ~(clr_we ? wr_data : 8'h00)) | evt; // see R09
      end
   end

   // Enable register
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         en_q <= 8'h00;
      end else if (en_we) begin
         en_q <= wr_data; // see R09
      end
   end

   // Registered output lags the flags by one cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & en_q);
      end
   end

   property p_set_wins;
      @(posedge core_clk) disable iff (!rst_b)
      (evt != 8'h00) |=> (flag_q & $past(evt)) == $past(evt);
   endproperty
   a_set_wins: assert property (p_set_wins) // see R09
      else $error("event lost against clear");

   property p_irq_level;
      @(posedge core_clk) disable iff (!rst_b)
      |(flag_q & en_q) |=> irq_q;
   endproperty
   a_irq_level: assert property (p_irq_level) // see R09
      else $error("interrupt not raised");
endmodule

// *** core/dmr_regset.sv ***
// APB register set of the eight-channel DMA controller
// Summary of operation
// R01: Eight channels 0..7, each holding its own full register copy.
// R02: Control, request select, starts and peripheral address are 16 bits.
// R03: Transfer count register is 10 bits wide.
// R04: Shared status holds per-channel RAM and peripheral collision flags.
// R05: Second shared status shows channel activity and ping-pong buffer.
// R06: Control, request, peripheral address and count read back as written; control returns only bits 15:11, 5:4 and 1:0, others read 0.
// R07: Reading a start address returns the live RAM address pointer.
// R08: Writing a start address stores into that start register.
// R09: Channel interrupt flag, enable and priority live in irq registers.
// R10: Control bit 15 enables the channel, cleared at reset.
// R11: Control bit 13 selects RAM-to-peripheral or peripheral-to-RAM.
// R12: Control bit 12 raises the interrupt at half block or full block.
// R13: Bits 5:4 select addressing; code 10 is peripheral indirect.
// R14: Bits 1:0 select one-shot/continuous, code 11 and 10 with ping-pong.
// R15: Control bit 14 selects byte transfers when set, words when clear.
// R16: Bit 11 adds a null peripheral write per RAM write, if direction clear.
module dmr_regset
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dmr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transfer engine state, same clock
   input wire logic [7:0][15:0] ram_ptr,
   input wire logic [7:0] chan_busy,
   input wire logic [7:0] pingpong_sel,
   input wire logic [7:0] ram_col_evt,
   input wire logic [7:0] per_col_evt,
   input wire logic [7:0] half_evt,
   input wire logic [7:0] done_evt,
   // Configuration to the transfer engine
   output dmr_pkg::dmr_chan_cfg_t [7:0] chan_cfg,
   output logic [7:0] null_write_on,
   output logic [23:0] chan_irq_priority,
   output logic irq
);
   import dmr_pkg::*;

   logic setup;
   logic access_wr;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pslverr_q;
   logic pslverr_d;
   logic [7:0] chan_wr;
   logic [7:0] ram_write_collision_flag_q;
   logic [7:0] periph_write_collision_flag_q;
   logic [7:0] null_write_on_q;
   logic [23:0] prio_q;
   logic [7:0] chan_irq_evt;
   logic [7:0] chan_irq_flag;
   logic [7:0] chan_irq_enable;
   logic irq_line;
   logic shared_sel;
   logic [2:0] sel_chan;
   logic [2:0] sel_idx;

   // True when the address lies on a defined register
   function automatic logic addr_mapped(logic [ADDR_W-1:0] a);
      logic ok;
      ok = 1'b0;
      if (a[1:0] == 2'h0 && a[ADDR_W-1:9] == '0) begin
         ok = a[4:2] <= IDX_CNT;
      end
      return ok;
   endfunction

   // Address split shared by read and write paths
   assign shared_sel = paddr[8];
   assign sel_chan = paddr[7:5];
   assign sel_idx = paddr[4:2];
   assign setup = psel && !penable;
   // Zero-wait slave: writes land on the single access cycle
   assign access_wr = psel && penable && pready_q && pwrite && !pslverr_q;

   // One write strobe per channel copy
   always_comb begin
      chan_wr = 8'h00;
      if (access_wr && !shared_sel) begin
         chan_wr[sel_chan] = 1'b1; // see R01
      end
   end

   // Eight independent register copies
   for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      dmr_chan u_chan (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .wr_en(chan_wr[ch]), // see R01
         .wr_idx(sel_idx),
         .wr_data(pwdata[15:0]),
         .cfg(chan_cfg[ch])
      );
   end

   // Interrupt raised at half or whole block as each channel asks
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         chan_irq_evt[i] = chan_cfg[i].irq_at_half ? half_evt[i]
                                                   : done_evt[i]; // see R12
      end
   end

   // Flag, enable and level output sit in the interrupt block
   dmr_irq u_irq (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .evt(chan_irq_evt),
      .clr_we(access_wr && shared_sel && sel_idx == IDX_IRQ_CLR),
      .en_we(access_wr && shared_sel && sel_idx == IDX_IRQ_EN),
      .wr_data(pwdata[7:0]),
      .flag_q(chan_irq_flag),
      .en_q(chan_irq_enable),
      .irq_q(irq_line)
   );

   // Null write honoured only for RAM-to-peripheral off; the stored
   // bit still reads back so software sees what it wrote
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         null_write_on_q <= 8'h00;
      end else begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            null_write_on_q[i] <= chan_cfg[i].dummy_peripheral_write &&
                                  !chan_cfg[i].ram_to_periph; // see R16
         end
      end
   end

   // Priority fields, three bits per channel
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prio_q <= PRIO_RST;
      end else if (access_wr && shared_sel && sel_idx == IDX_IRQ_PRIO) begin
         prio_q <= pwdata[23:0]; // see R09
      end
   end

   // Collision flags are write-one-to-clear; a new hit wins over a clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ram_write_collision_flag_q <= 8'h00;
         periph_write_collision_flag_q <= 8'h00;
      end else begin
         if (access_wr && shared_sel && sel_idx == IDX_COLL) begin
            ram_write_collision_flag_q <=
               (ram_write_collision_flag_q & ~pwdata[7:0]) | ram_col_evt;
            periph_write_collision_flag_q <=
               (periph_write_collision_flag_q & ~pwdata[15:8]) | per_col_evt;
         end else begin
            ram_write_collision_flag_q <=
               ram_write_collision_flag_q | ram_col_evt; // see R04
            periph_write_collision_flag_q <=
               periph_write_collision_flag_q | per_col_evt; // see R04
         end
      end
   end

   // Read data is chosen in the setup cycle so pready can be a flop
   always_comb begin
      prdata_d = 32'h00000000;
      pslverr_d = !addr_mapped(paddr);
      if (!shared_sel) begin
         unique case (sel_idx)
            IDX_CTRL: prdata_d[15:0] = dmr_ctrl_word(chan_cfg[sel_chan]);
            IDX_REQ: prdata_d[15:0] = chan_cfg[sel_chan].request_select;
            IDX_STA: prdata_d[15:0] = ram_ptr[sel_chan]; // see R07
            IDX_STB: prdata_d[15:0] = ram_ptr[sel_chan]; // see R07
            IDX_PAD: prdata_d[15:0] = chan_cfg[sel_chan].periph_address;
            IDX_CNT: prdata_d[9:0] = chan_cfg[sel_chan].transfer_count;
            default: ;
         endcase
      end else begin
         unique case (sel_idx)
            IDX_COLL: prdata_d[15:0] = {periph_write_collision_flag_q,
                                        ram_write_collision_flag_q};
            IDX_PPSTAT: prdata_d[15:0] = {pingpong_sel,
                                          chan_busy}; // see R05
            IDX_IRQ_FLAG: prdata_d[7:0] = chan_irq_flag;
            IDX_IRQ_CLR: prdata_d[7:0] = 8'h00; // Write-only
            IDX_IRQ_EN: prdata_d[7:0] = chan_irq_enable;
            IDX_IRQ_PRIO: prdata_d[23:0] = prio_q;
            default: ;
         endcase
      end
   end

   // APB handshake: pready rises for exactly the first access cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && pslverr_d;
      end
   end

   // Read data captured once per transfer, held through the access cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= (pwrite || pslverr_d) ? 32'h00000000 : prdata_d;
      end
   end

   // Outputs driven straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_line;
   assign null_write_on = null_write_on_q;
   assign chan_irq_priority = prio_q;

   property p_pready_once;
      @(posedge core_clk) disable iff (!rst_b)
      setup |=> pready ##1 !pready;
   endproperty
   a_pready_once: assert property (p_pready_once)
      else $error("pready not a single access cycle");

   property p_start_reads_ptr;
      @(posedge core_clk) disable iff (!rst_b)
      setup && !pwrite && !pslverr_d && !shared_sel && sel_idx == IDX_STA |=>
         prdata[15:0] == $past(ram_ptr[sel_chan]) &&
         prdata[31:16] == 16'h0000;
   endproperty
   a_start_reads_ptr: assert property (p_start_reads_ptr) // see R07
      else $error("start read did not return pointer");

   property p_coll_sticky;
      @(posedge core_clk) disable iff (!rst_b)
      ram_col_evt[3] |=> ram_write_collision_flag_q[3] [*2] or
         (ram_write_collision_flag_q[3] ##1 $past(access_wr));
   endproperty
   a_coll_sticky: assert property (p_coll_sticky) // see R04
      else $error("collision flag not set");

   property p_ppstat_read;
      @(posedge core_clk) disable iff (!rst_b)
      setup && !pwrite && !pslverr_d && shared_sel && sel_idx == IDX_PPSTAT |=>
         prdata[15:0] == {$past(pingpong_sel), $past(chan_busy)};
   endproperty
   a_ppstat_read: assert property (p_ppstat_read) // see R05
      else $error("ping-pong status read wrong");

   property p_null_gate;
      @(posedge core_clk) disable iff (!rst_b)
      null_write_on[1] |-> $past(!chan_cfg[1].ram_to_periph);
   endproperty
   a_null_gate: assert property (p_null_gate) // see R16
      else $error("null write with RAM source");

   property p_half_select;
      @(posedge core_clk) disable iff (!rst_b)
      chan_cfg[6].irq_at_half && half_evt[6] |=> chan_irq_flag[6];
   endproperty
   a_half_select: assert property (p_half_select) // see R12
      else $error("half block interrupt missed");

   property p_chan_isolated;
      @(posedge core_clk) disable iff (!rst_b)
      chan_wr[0] |=> chan_cfg[1] == $past(chan_cfg[1]);
   endproperty
   a_chan_isolated: assert property (p_chan_isolated) // see R01
      else $error("write leaked into another channel");

   property p_unmapped_err;
      @(posedge core_clk) disable iff (!rst_b)
      setup && paddr[1:0] != 2'h0 |=> pslverr && pready;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access not flagged");

   property p_on_reset;
      @(posedge core_clk)
      !rst_b |=> chan_cfg == '0 && !irq;
   endproperty
   a_on_reset: assert property (p_on_reset) // see R10
      else $error("reset did not clear");

   property p_dir_bit;
      @(posedge core_clk) disable iff (!rst_b)
      chan_wr[1] && sel_idx == IDX_CTRL |=>
         chan_cfg[1].ram_to_periph == $past(pwdata[CTL_DIR]);
   endproperty
   a_dir_bit: assert property (p_dir_bit) // see R11
      else $error("direction bit misplaced");

   property p_size_bit;
      @(posedge core_clk) disable iff (!rst_b)
      chan_wr[1] && sel_idx == IDX_CTRL |=>
         chan_cfg[1].byte_unit == $past(pwdata[CTL_SIZE]);
   endproperty
   a_size_bit: assert property (p_size_bit) // see R15
      else $error("size bit misplaced");

   property p_addressing_kind_code;
      @(posedge core_clk) disable iff (!rst_b)
      chan_wr[1] && sel_idx == IDX_CTRL |=> chan_cfg[1].periph_indirect ==
         ($past(pwdata[CTL_AM_LO+:2]) == AM_PERIPH);
   endproperty
   a_addressing_kind_code: assert property (p_addressing_kind_code) // see R13
      else $error("addressing code misdecoded");

   property p_opmode_code;
      @(posedge core_clk) disable iff (!rst_b)
      chan_wr[1] && sel_idx == IDX_CTRL |=>
         {chan_cfg[1].ping_pong, chan_cfg[1].one_shot} ==
         $past(pwdata[CTL_OP_LO+:2]);
   endproperty
   a_opmode_code: assert property (p_opmode_code) // see R14
      else $error("operating mode misdecoded");

   property p_req_read;
      @(posedge core_clk) disable iff (!rst_b)
      setup && !pwrite && !pslverr_d && !shared_sel && sel_idx == IDX_REQ
      |=> prdata == {16'h0000, $past(chan_cfg[sel_chan].request_select)};
   endproperty
   a_req_read: assert property (p_req_read) // see R06
      else $error("request select read back wrong");

   property p_prio_write;
      @(posedge core_clk) disable iff (!rst_b)
      access_wr && shared_sel && sel_idx == IDX_IRQ_PRIO |=>
         chan_irq_priority == $past(pwdata[23:0]);
   endproperty
   a_prio_write: assert property (p_prio_write) // see R09
      else $error("priority write not stored");
endmodule

// *** dv/dmr_engine_model.sv ***
// Behavioural transfer engine facing the register set
module dmr_engine_model
   import dmr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Configuration and bench commands
   input dmr_pkg::dmr_chan_cfg_t [7:0] chan_cfg,
   input wire logic ev_go,
   input wire logic [1:0] ev_kind,
   input wire logic [2:0] ev_chan,
   // Engine state towards the register set
   output logic [7:0][15:0] ram_ptr,
   output logic [7:0] chan_busy,
   output logic [7:0] pingpong_sel,
   output logic [3:0][7:0] evt_q
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pointer kept apart from any start value, so a stored read-back shows
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ram_ptr[i] = 16'hC000 | 16'(i);
         chan_busy[i] = chan_cfg[i].channel_on;
      end
   end

   // Events are one-cycle pulses; a ping-pong channel's buffer flips at each block end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         evt_q <= '0;
         pingpong_sel <= 8'h00;
      end else begin
         evt_q <= '0;
         if (ev_go) begin
            evt_q[ev_kind][ev_chan] <= 1'b1;
            if (ev_kind == 2'h3 && chan_cfg[ev_chan].ping_pong) begin
               pingpong_sel[ev_chan] <= ~pingpong_sel[ev_chan];
            end
         end
      end
   end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the DMA channel register set
module tb_top
   import dmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [7:0][15:0] ram_ptr;
   logic [7:0] chan_busy;
   logic [7:0] pingpong_sel;
   logic [7:0] null_write_on;
   logic [3:0][7:0] evt;
   dmr_chan_cfg_t [7:0] chan_cfg;
   logic [23:0] chan_irq_priority;
   logic ev_go = 1'b0;
   logic [1:0] ev_kind = 2'h0;
   logic [2:0] ev_chan = 3'h0;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [15:0] tv [13] = '{16'h0000, 16'h8000, 16'h4000, 16'h2000,
      16'h1000, 16'h0800, 16'h2800, 16'h0010, 16'h0020, 16'h0001,
      16'h0002, 16'h0003, 16'h0000};
   logic [11:0] bad [4] = '{12'h018, 12'h002, 12'h200, 12'h118};

   always #50 core_clk = ~core_clk;

   // Design under test, engine side fed by the model
   dmr_regset dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ram_ptr(ram_ptr), .chan_busy(chan_busy),
      .pingpong_sel(pingpong_sel), .ram_col_evt(evt[0]),
      .per_col_evt(evt[1]), .half_evt(evt[2]), .done_evt(evt[3]),
      .chan_cfg(chan_cfg), .null_write_on(null_write_on),
      .chan_irq_priority(chan_irq_priority), .irq(irq));

   dmr_engine_model eng_u (.core_clk(core_clk), .rst_b(rst_b),
      .chan_cfg(chan_cfg), .ev_go(ev_go), .ev_kind(ev_kind),
      .ev_chan(ev_chan), .ram_ptr(ram_ptr), .chan_busy(chan_busy),
      .pingpong_sel(pingpong_sel), .evt_q(evt));

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk({31'h0, pready}, 32'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   // Model event: 0 RAM collision, 1 peripheral, 2 half, 3 done
   task automatic fire(input logic [1:0] k, input logic [2:0] c);
      @(posedge core_clk);
      ev_go <= 1'b1;
      ev_kind <= k;
      ev_chan <= c;
      @(posedge core_clk);
      ev_go <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   function automatic logic [11:0] ca(input int x, input logic [2:0] i);
      return 12'(x) * CHAN_STRIDE + {7'h0, i, 2'b00};
   endfunction

   function automatic logic [11:0] sa(input logic [2:0] i);
      return SHARED_BASE + {7'h0, i, 2'b00};
   endfunction

   // Expected decode of a control word, bit by bit
   function automatic logic [31:0] dec(input logic [15:0] v);
      return {21'h0, v[15:11], v[5:4] == 2'h2, v[5:4] == 2'h0, v[1:0],
              v[5:4]};
   endfunction

   // Hang guard, far above the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(ca(0, IDX_CTRL), 32'h0);
      rd(sa(IDX_PPSTAT), 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("Test reset done");
      // Write all copies first so aliasing between channels shows
      for (int x = 0; x < 8; x++) begin
         wr(ca(x, IDX_CTRL), 32'hFFFF);
         wr(ca(x, IDX_REQ), 32'hA500 | 32'(x));
         wr(ca(x, IDX_PAD), 32'h5A00 | 32'(x));
         wr(ca(x, IDX_CNT), 32'hFFF0 | 32'(x));
      end
      for (int x = 0; x < 8; x++) begin
         rd(ca(x, IDX_CTRL), 32'hF833);
         rd(ca(x, IDX_REQ), 32'hA500 | 32'(x));
         rd(ca(x, IDX_PAD), 32'h5A00 | 32'(x));
         rd(ca(x, IDX_CNT), 32'h3F0 | 32'(x));
         chk({31'h0, null_write_on[x]}, 32'h0);
         wr(ca(x, IDX_CTRL), 32'h0);
      end
      $display("Test channel copies done");
      foreach (tv[i]) begin
         wr(ca(1, IDX_CTRL), {16'h0, tv[i]});
         rd(ca(1, IDX_CTRL), {16'h0, tv[i]});
         chk({21'h0, chan_cfg[1].channel_on, chan_cfg[1].byte_unit,
            chan_cfg[1].ram_to_periph, chan_cfg[1].irq_at_half,
            chan_cfg[1].dummy_peripheral_write, chan_cfg[1].periph_indirect,
            chan_cfg[1].post_inc, chan_cfg[1].ping_pong, chan_cfg[1].one_shot,
            chan_cfg[1].addressing_kind},
            dec(tv[i]));
         chk({31'h0, null_write_on[1]},
             {31'h0, tv[i][11] & ~tv[i][13]});
      end
      $display("Test control decode done");
      wr(ca(4, IDX_STA), 32'h1234);
      wr(ca(4, IDX_STB), 32'h5678);
      @(posedge core_clk); // Storage updates on the edge just passed
      chk({16'h0, chan_cfg[4].ram_start_a}, 32'h1234);
      chk({16'h0, chan_cfg[4].ram_start_b}, 32'h5678);
      rd(ca(4, IDX_STA), 32'hC004);
      rd(ca(4, IDX_STB), 32'hC004);
      $display("Test start address done");
      wr(ca(6, IDX_CTRL), 32'h8002);
      fire(2'h3, 3'h6);
      rd(sa(IDX_PPSTAT), 32'h4040);
      fire(2'h0, 3'h3);
      fire(2'h1, 3'h5);
      rd(sa(IDX_COLL), 32'h2008);
      wr(sa(IDX_COLL), 32'h0008);
      rd(sa(IDX_COLL), 32'h2000);
      $display("Test status done");
      rd(sa(IDX_IRQ_FLAG), 32'h40);
      chk({31'h0, irq}, 32'h0);
      wr(sa(IDX_IRQ_EN), 32'h40);
      rd(sa(IDX_IRQ_EN), 32'h40);
      chk({31'h0, irq}, 32'h1);
      wr(sa(IDX_IRQ_CLR), 32'h40);
      rd(sa(IDX_IRQ_CLR), 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ca(6, IDX_CTRL), 32'h9002);
      fire(2'h3, 3'h6);
      rd(sa(IDX_IRQ_FLAG), 32'h0);
      fire(2'h2, 3'h6);
      rd(sa(IDX_IRQ_FLAG), 32'h40);
      chk({31'h0, irq}, 32'h1);
      wr(sa(IDX_IRQ_PRIO), 32'hFAC688);
      rd(sa(IDX_IRQ_PRIO), 32'hFAC688);
      chk({8'h0, chan_irq_priority}, 32'hFAC688);
      $display("Test interrupt done");
      // Unmapped places refuse and leave storage alone
      foreach (bad[i]) begin
         apb(1'b1, bad[i], 32'hFFFF);
         chk({31'h0, rerr}, 32'h1);
         apb(1'b0, bad[i], 32'h0);
         chk({31'h0, rerr}, 32'h1);
         chk(rdat, 32'h0);
      end
      rd(ca(0, IDX_CTRL), 32'h0);
      $display("Test unmapped done");
      stop_test();
   end
endmodule
